// *** rmb_pkg.sv ***
`default_nettype none
// =====================================================================
// shared constants for the register mailbox serial bridge
package rmb_pkg;
	// control block indices; byte address is four times the index
	localparam logic [2:0]  IDX_TX_PTR   = 3'h0;
	localparam logic [2:0]  IDX_TX_CMD   = 3'h1;
	localparam logic [2:0]  IDX_RX_PTR   = 3'h2;
	localparam logic [2:0]  IDX_RX_CMD   = 3'h3;
	localparam logic [2:0]  IDX_TERM     = 3'h4;
	localparam logic [2:0]  IDX_RX_LEN   = 3'h5;
	localparam logic [11:0] ADDR_CTRL_END = 12'h018;
	localparam logic [11:0] ADDR_CFG     = 12'h020;
	localparam logic [11:0] ADDR_TOUT    = 12'h024;
	localparam logic [11:0] ADDR_NET     = 12'h028;
	localparam logic [11:0] ADDR_STAT    = 12'h02C;
	localparam logic [11:0] ADDR_MEM     = 12'h400;
	localparam logic [11:0] ADDR_MEM_END = 12'h800;
	// command register values
	localparam logic [15:0] TXC_IDLE     = 16'h0000;
	localparam logic [15:0] TXC_REQ      = 16'h0001;
	localparam logic [15:0] RXC_READY    = 16'h0000;
	localparam logic [15:0] RXC_DONE     = 16'h0001;
	localparam logic [15:0] RXC_FLUSH    = 16'h0002;
	localparam logic [15:0] RXC_FLUSHED  = 16'h0003;
	localparam logic [15:0] RXC_ERR      = 16'hFFFF;
	localparam logic [7:0]  MAX_BYTES    = 8'hFE;
	// config fields and reset values
	localparam int          CFG_ETH      = 0;
	localparam int          CFG_PORT_LO  = 1;
	localparam int          CFG_BR_EN    = 3;
	localparam int          NET_UDP      = 16;
	localparam int          NET_CTRL2    = 17;
	localparam logic [15:0] TCP_PORT_RST = 16'h1774;
	localparam logic [15:0] TOUT_RST     = 16'h000A;
	localparam logic [1:0]  RESP_OK      = 2'h0;
	localparam logic [1:0]  RESP_SLVERR  = 2'h2;
	// timing
	localparam int          CLK_NS       = 50;
	localparam int          ONE_SEC_NS   = 1000000000;
	localparam int          RX_GAP_US    = 10000;
	localparam int          SEC_CYC      = ONE_SEC_NS / CLK_NS;
	localparam int          RX_GAP_CYC   = RX_GAP_US * 1000 / CLK_NS;
	typedef enum logic [2:0] {R_CTRL, R_CFG, R_TOUT, R_NET, R_STAT, R_MEM, R_NONE} rmb_reg_t;
	typedef struct packed {
		logic        we;
		logic [7:0]  addr;
		logic [15:0] data;
	} rmb_memwr_t;
endpackage : rmb_pkg
`default_nettype wire

// *** rmb_bridge.sv ***
`default_nettype none
module rmb_bridge #(
	parameter int unsigned SEC_CYC = rmb_pkg::SEC_CYC,
	parameter int unsigned GAP_CYC = rmb_pkg::RX_GAP_CYC
) (
	// clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// axi4-lite slave
	input  wire logic [11:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [11:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// port byte streams
	input  wire logic        rx_byte_valid,
	input  wire logic [7:0]  rx_byte_data,
	output logic             tx_byte_valid,
	output logic [7:0]       tx_byte_data,
	input  wire logic        tx_byte_ready,
	// mode and bridge
	input  wire logic        raw_mode_sel,
	input  wire logic        pc_traffic,
	output logic             bridge_active,
	output logic             bridge_eth,
	output logic [1:0]       bridge_port,
	output logic             bridge_udp,
	output logic             bridge_ctrl2,
	output logic [15:0]      bridge_tcp_port
);
	// =================================================================
	// helpers
	function automatic rmb_pkg::rmb_reg_t rmb_decode(input logic [11:0] a);
		if (a[1:0] != 2'h0)
			return rmb_pkg::R_NONE;
		if (a >= rmb_pkg::ADDR_MEM && a < rmb_pkg::ADDR_MEM_END)
			return rmb_pkg::R_MEM;
		if (a < rmb_pkg::ADDR_CTRL_END)
			return rmb_pkg::R_CTRL;
		case (a)
			rmb_pkg::ADDR_CFG:  return rmb_pkg::R_CFG;
			rmb_pkg::ADDR_TOUT: return rmb_pkg::R_TOUT;
			rmb_pkg::ADDR_NET:  return rmb_pkg::R_NET;
			rmb_pkg::ADDR_STAT: return rmb_pkg::R_STAT;
			default:            return rmb_pkg::R_NONE;
		endcase
	endfunction

	function automatic logic [15:0] merge16(input logic [15:0] o, input logic [31:0] d,
		input logic [3:0] s);
		return {s[1] ? d[15:8] : o[15:8], s[0] ? d[7:0] : o[7:0]};
	endfunction

	// =================================================================
	// axi write channel
	logic        aw_got_r, w_got_r, bvalid_r, awready_r, wready_r;
	logic [1:0]  bresp_r;
	logic [11:0] waddr_r;
	logic [31:0] wdata_r;
	logic [3:0]  wstrb_r;
	rmb_pkg::rmb_reg_t wreg;
	rmb_pkg::rmb_memwr_t eng_wr_r;
	logic        aw_take, w_take, b_done, wr_do, wr_ctrl;

	assign wreg    = rmb_decode(waddr_r);
	assign aw_take = s_axi_awvalid & awready_r;
	assign w_take  = s_axi_wvalid & wready_r;
	assign b_done  = bvalid_r & s_axi_bready;
	// a buffer write waits while the receive engine owns the memory port
	assign wr_do   = aw_got_r & w_got_r & ~bvalid_r & ~(wreg == rmb_pkg::R_MEM & eng_wr_r.we);
	assign wr_ctrl = wr_do & (wreg == rmb_pkg::R_CTRL);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_r  <= 1'b0;
			w_got_r   <= 1'b0;
			awready_r <= 1'b0;
			wready_r  <= 1'b0;
			bvalid_r  <= 1'b0;
			bresp_r   <= rmb_pkg::RESP_OK;
			waddr_r   <= 12'h000;
			wdata_r   <= 32'h0000_0000;
			wstrb_r   <= 4'h0;
		end else begin
			aw_got_r  <= ~b_done & (aw_got_r | aw_take);
			w_got_r   <= ~b_done & (w_got_r | w_take);
			awready_r <= b_done | ~(aw_got_r | aw_take);
			wready_r  <= b_done | ~(w_got_r | w_take);
			if (aw_take)
				waddr_r <= s_axi_awaddr;
			if (w_take) begin
				wdata_r <= s_axi_wdata;
				wstrb_r <= s_axi_wstrb;
			end
			if (wr_do) begin
				bvalid_r <= 1'b1;
				bresp_r  <= (wreg == rmb_pkg::R_NONE || wreg == rmb_pkg::R_STAT) ?
					rmb_pkg::RESP_SLVERR : rmb_pkg::RESP_OK;
			end else if (b_done)
				bvalid_r <= 1'b0;
		end
	end

	// =================================================================
	// control block and own configuration
	logic [15:0] tx_ptr_r, rx_ptr_r, term_r, rx_len_r, tx_cmd_r, rx_cmd_r;
	logic [3:0]  cfg_r;
	logic [15:0] tout_r;
	logic [17:0] net_r;

	// plain control words, four of the six
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tx_ptr_r <= 16'h0000;
			rx_ptr_r <= 16'h0000;
			term_r   <= 16'h0000;
			rx_len_r <= 16'h0000;
		end else if (wr_ctrl) begin
			case (waddr_r[4:2])
				rmb_pkg::IDX_TX_PTR: tx_ptr_r <= merge16(tx_ptr_r, wdata_r, wstrb_r);
				rmb_pkg::IDX_RX_PTR: rx_ptr_r <= merge16(rx_ptr_r, wdata_r, wstrb_r);
				rmb_pkg::IDX_TERM:   term_r   <= merge16(term_r, wdata_r, wstrb_r);
				rmb_pkg::IDX_RX_LEN: rx_len_r <= merge16(rx_len_r, wdata_r, wstrb_r);
				default: ;
			endcase
		end
	end

	// bridge settings: single port field, link kind, target, transport
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cfg_r  <= 4'h0;
			tout_r <= rmb_pkg::TOUT_RST;
			net_r  <= {2'b00, rmb_pkg::TCP_PORT_RST};
		end else if (wr_do) begin
			if (wreg == rmb_pkg::R_CFG)
				cfg_r <= wdata_r[3:0];
			if (wreg == rmb_pkg::R_TOUT)
				tout_r <= merge16(tout_r, wdata_r, wstrb_r);
			if (wreg == rmb_pkg::R_NET && wstrb_r[2])
				net_r[17:16] <= wdata_r[17:16];
			if (wreg == rmb_pkg::R_NET)
				net_r[15:0] <= merge16(net_r[15:0], wdata_r, wstrb_r);
		end
	end

	// =================================================================
	// mode select and pass-through bridging
	logic        raw_prev_r, mode_edge, pt_act_r, pt_ok;
	logic [31:0] sec_cnt_r;
	logic [15:0] pt_sec_r;

	assign mode_edge = raw_mode_sel ^ raw_prev_r;
	assign pt_ok     = cfg_r[rmb_pkg::CFG_BR_EN] & ~raw_mode_sel;

	// idle timer restarts on every bridged exchange
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			raw_prev_r <= 1'b0;
			pt_act_r   <= 1'b0;
			sec_cnt_r  <= 32'h0000_0000;
			pt_sec_r   <= 16'h0000;
		end else begin
			raw_prev_r <= raw_mode_sel;
			if (!pt_ok)
				pt_act_r <= 1'b0;
			else if (pc_traffic) begin
				pt_act_r  <= 1'b1;
				sec_cnt_r <= 32'h0000_0000;
				pt_sec_r  <= 16'h0000;
			end else if (pt_act_r) begin
				if (tout_r != 16'h0000 && pt_sec_r == tout_r)
					pt_act_r <= 1'b0;
				if (sec_cnt_r == 32'(SEC_CYC - 1)) begin
					sec_cnt_r <= 32'h0000_0000;
					pt_sec_r  <= pt_sec_r + 16'h0001;
				end else
					sec_cnt_r <= sec_cnt_r + 32'h0000_0001;
			end
		end
	end

	// =================================================================
	// buffer memory shared by software and both engines
	logic [15:0] mem_r [256];

	// engine writes first; software buffer writes wait in wr_do
	always_ff @(posedge aclk) begin
		if (eng_wr_r.we)
			mem_r[eng_wr_r.addr] <= eng_wr_r.data;
		else if (wr_do && wreg == rmb_pkg::R_MEM)
			mem_r[waddr_r[9:2]] <= merge16(mem_r[waddr_r[9:2]], wdata_r, wstrb_r);
	end

	// =================================================================
	// transmit engine, high byte of each word first
	typedef enum logic {TX_IDLE, TX_SEND} rmb_tx_t;
	rmb_tx_t     tx_st_r;
	logic [7:0]  tx_rem_r, tx_wi_r;
	logic        tx_hi_r, tx_valid_r, tx_done;
	logic [7:0]  tx_data_r;
	logic [15:0] tx_len, tx_word;

	assign tx_len  = mem_r[tx_ptr_r[7:0]];
	assign tx_word = mem_r[tx_wi_r];
	assign tx_done = (tx_st_r == TX_SEND) & ~tx_valid_r & (tx_rem_r == 8'h00);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tx_st_r    <= TX_IDLE;
			tx_rem_r   <= 8'h00;
			tx_wi_r    <= 8'h00;
			tx_hi_r    <= 1'b1;
			tx_valid_r <= 1'b0;
			tx_data_r  <= 8'h00;
		end else begin
			case (tx_st_r)
				TX_IDLE: begin
					if (tx_cmd_r == rmb_pkg::TXC_REQ && raw_mode_sel && !pt_act_r) begin
						tx_rem_r <= (tx_len > {8'h00, rmb_pkg::MAX_BYTES}) ?
							rmb_pkg::MAX_BYTES : tx_len[7:0];
						tx_wi_r  <= tx_ptr_r[7:0] + 8'h01;
						tx_hi_r  <= 1'b1;
						tx_st_r  <= TX_SEND;
					end
				end
				TX_SEND: begin
					if (tx_valid_r) begin
						if (tx_byte_ready) begin
							tx_valid_r <= 1'b0;
							tx_rem_r   <= tx_rem_r - 8'h01;
							tx_hi_r    <= ~tx_hi_r;
							if (!tx_hi_r)
								tx_wi_r <= tx_wi_r + 8'h01;
						end
					end else if (tx_rem_r == 8'h00)
						tx_st_r <= TX_IDLE;
					else if (!pt_act_r) begin
						tx_data_r  <= tx_hi_r ? tx_word[15:8] : tx_word[7:0];
						tx_valid_r <= 1'b1;
					end
				end
				default: tx_st_r <= TX_IDLE;
			endcase
		end
	end

	// software request wins over completion in the same cycle
	always_ff @(posedge aclk) begin
		if (!aresetn)
			tx_cmd_r <= rmb_pkg::TXC_IDLE;
		else if (wr_ctrl && waddr_r[4:2] == rmb_pkg::IDX_TX_CMD)
			tx_cmd_r <= merge16(tx_cmd_r, wdata_r, wstrb_r);
		else if (tx_done)
			tx_cmd_r <= rmb_pkg::TXC_IDLE;
	end

	// =================================================================
	// receive engine
	logic [7:0]  rx_n_r, rx_hold_r, rx_prev_r, n1;
	logic        rx_fin_r, rx_err_r, rx_acc, term_hit, len_hit, end_ok, rx_full;
	logic        gap_to, flush;
	logic [31:0] gap_r;
	logic [7:0]  rx_wa;

	// bytes are dropped, not queued, until software writes ready
	assign rx_acc   = rx_byte_valid & raw_mode_sel & ~pt_act_r & ~rx_fin_r
		& (rx_cmd_r == rmb_pkg::RXC_READY);
	assign n1       = rx_n_r + 8'h01;
	assign term_hit = (term_r[15:8] != 8'h00) ?
		(rx_n_r != 8'h00 && rx_prev_r == term_r[15:8] && rx_byte_data == term_r[7:0]) :
		(rx_byte_data == term_r[7:0]);
	assign len_hit  = (rx_len_r == {8'h00, n1});
	assign end_ok   = (rx_len_r == 16'h0000) ? term_hit : len_hit;
	assign rx_full  = (n1 == rmb_pkg::MAX_BYTES);
	assign gap_to   = (rx_n_r != 8'h00) & ~rx_fin_r & (gap_r == 32'(GAP_CYC - 1));
	assign flush    = mode_edge | (rx_cmd_r == rmb_pkg::RXC_FLUSH);
	assign rx_wa    = rx_ptr_r[7:0] + 8'h01 + {1'b0, rx_n_r[7:1]};

	always_ff @(posedge aclk) begin
		if (!aresetn || flush) begin
			rx_n_r    <= 8'h00;
			rx_hold_r <= 8'h00;
			rx_prev_r <= 8'h00;
			rx_fin_r  <= 1'b0;
			rx_err_r  <= 1'b0;
			gap_r     <= 32'h0000_0000;
			eng_wr_r  <= '0;
		end else begin
			eng_wr_r.we <= 1'b0;
			if (rx_acc) begin
				rx_prev_r <= rx_byte_data;
				rx_n_r    <= n1;
				gap_r     <= 32'h0000_0000;
				if (!rx_n_r[0])
					rx_hold_r <= rx_byte_data;
				if (rx_n_r[0] || end_ok || rx_full) begin
					eng_wr_r.we   <= 1'b1;
					eng_wr_r.addr <= rx_wa;
					eng_wr_r.data <= rx_n_r[0] ? {rx_hold_r, rx_byte_data}
						: {rx_byte_data, 8'h00};
				end
				if (end_ok || rx_full) begin
					rx_fin_r <= 1'b1;
					rx_err_r <= ~end_ok;
				end
			end else if (rx_fin_r) begin
				eng_wr_r.we   <= 1'b1;
				eng_wr_r.addr <= rx_ptr_r[7:0];
				eng_wr_r.data <= {8'h00, rx_n_r};
				rx_fin_r      <= 1'b0;
				rx_n_r        <= 8'h00;
			end else if (gap_to) begin
				rx_fin_r <= 1'b1;
				rx_err_r <= 1'b1;
				if (rx_n_r[0]) begin
					eng_wr_r.we   <= 1'b1;
					eng_wr_r.addr <= rx_wa;
					eng_wr_r.data <= {rx_hold_r, 8'h00};
				end
			end else if (rx_n_r != 8'h00)
				gap_r <= gap_r + 32'h0000_0001;
		end
	end

	// engine results win over a software write in the same cycle
	always_ff @(posedge aclk) begin
		if (!aresetn || mode_edge)
			rx_cmd_r <= rmb_pkg::RXC_FLUSHED;
		else if (rx_fin_r && !rx_acc && rx_cmd_r == rmb_pkg::RXC_READY)
			rx_cmd_r <= rx_err_r ? rmb_pkg::RXC_ERR : rmb_pkg::RXC_DONE;
		else if (wr_ctrl && waddr_r[4:2] == rmb_pkg::IDX_RX_CMD)
			rx_cmd_r <= merge16(rx_cmd_r, wdata_r, wstrb_r);
		else if (rx_cmd_r == rmb_pkg::RXC_FLUSH)
			rx_cmd_r <= rmb_pkg::RXC_FLUSHED;
	end

	// =================================================================
	// axi read channel
	logic        ar_take, r_done, rvalid_r, arready_r;
	logic [31:0] rdata_r, rd_word;
	logic [1:0]  rresp_r;
	rmb_pkg::rmb_reg_t rreg;

	assign rreg    = rmb_decode(s_axi_araddr);
	assign ar_take = s_axi_arvalid & arready_r;
	assign r_done  = rvalid_r & s_axi_rready;

	always_comb begin
		rd_word = 32'h0000_0000;
		case (rreg)
			rmb_pkg::R_CTRL: begin
				case (s_axi_araddr[4:2])
					rmb_pkg::IDX_TX_PTR: rd_word[15:0] = tx_ptr_r;
					rmb_pkg::IDX_TX_CMD: rd_word[15:0] = tx_cmd_r;
					rmb_pkg::IDX_RX_PTR: rd_word[15:0] = rx_ptr_r;
					rmb_pkg::IDX_RX_CMD: rd_word[15:0] = rx_cmd_r;
					rmb_pkg::IDX_TERM:   rd_word[15:0] = term_r;
					default:             rd_word[15:0] = rx_len_r;
				endcase
			end
			rmb_pkg::R_CFG:  rd_word[3:0]  = cfg_r;
			rmb_pkg::R_TOUT: rd_word[15:0] = tout_r;
			rmb_pkg::R_NET:  rd_word[17:0] = net_r;
			rmb_pkg::R_STAT: rd_word[10:0] = {pt_act_r, tx_st_r == TX_SEND, rx_fin_r, rx_n_r};
			rmb_pkg::R_MEM:  rd_word[15:0] = mem_r[s_axi_araddr[9:2]];
			default:         rd_word = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_r  <= 1'b0;
			arready_r <= 1'b0;
			rdata_r   <= 32'h0000_0000;
			rresp_r   <= rmb_pkg::RESP_OK;
		end else begin
			arready_r <= r_done | ~(rvalid_r | ar_take);
			if (ar_take) begin
				rvalid_r <= 1'b1;
				rdata_r  <= rd_word;
				rresp_r  <= (rreg == rmb_pkg::R_NONE) ? rmb_pkg::RESP_SLVERR : rmb_pkg::RESP_OK;
			end else if (r_done)
				rvalid_r <= 1'b0;
		end
	end

	// =================================================================
	// outputs, all from flip-flops
	assign s_axi_awready   = awready_r;
	assign s_axi_wready    = wready_r;
	assign s_axi_bvalid    = bvalid_r;
	assign s_axi_bresp     = bresp_r;
	assign s_axi_arready   = arready_r;
	assign s_axi_rvalid    = rvalid_r;
	assign s_axi_rdata     = rdata_r;
	assign s_axi_rresp     = rresp_r;
	assign tx_byte_valid   = tx_valid_r;
	assign tx_byte_data    = tx_data_r;
	assign bridge_active   = pt_act_r;
	assign bridge_eth      = cfg_r[rmb_pkg::CFG_ETH];
	assign bridge_port     = cfg_r[rmb_pkg::CFG_PORT_LO +: 2];
	assign bridge_udp      = net_r[rmb_pkg::NET_UDP];
	assign bridge_ctrl2    = net_r[rmb_pkg::NET_CTRL2];
	assign bridge_tcp_port = net_r[15:0];

	// =================================================================
	// checks
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_flush_done: assert property ((rx_cmd_r == rmb_pkg::RXC_FLUSH && !wr_ctrl && !mode_edge)
		|=> rx_cmd_r == rmb_pkg::RXC_FLUSHED) else $error("flush not acknowledged");
	a_mode_flush: assert property (mode_edge |=> rx_cmd_r == rmb_pkg::RXC_FLUSHED && rx_n_r == 8'h00)
		else $error("mode change did not flush");
	a_tx_complete: assert property ((tx_done && !wr_ctrl) |=> tx_cmd_r == rmb_pkg::TXC_IDLE)
		else $error("transmit command not cleared");
	a_rx_after_ready: assert property ((rx_cmd_r == rmb_pkg::RXC_DONE && $past(rx_cmd_r)
		!= rmb_pkg::RXC_DONE && !$past(wr_ctrl)) |-> $past(rx_cmd_r) == rmb_pkg::RXC_READY)
		else $error("message posted without ready");
	a_tx_suspend: assert property ($rose(tx_valid_r) |-> !$past(pt_act_r))
		else $error("own traffic during bridging");
	a_pt_enter: assert property ((pt_ok && pc_traffic) |=> bridge_active ##1 (bridge_active || !pt_ok
		|| tout_r != 16'h0000)) else $error("bridging lock missing");
	a_pt_leave: assert property ((pt_act_r && pt_ok && !pc_traffic && tout_r != 16'h0000
		&& pt_sec_r == tout_r) |=> !pt_act_r) else $error("bridge timeout ignored");
	a_rx_limit: assert property (rx_n_r <= rmb_pkg::MAX_BYTES)
		else $error("receive count over limit");
	a_tx_limit: assert property (tx_rem_r <= rmb_pkg::MAX_BYTES)
		else $error("transmit count over limit");
	a_fixed_len: assert property ((rx_acc && len_hit && rx_len_r != 16'h0000) |=> rx_fin_r
		##1 (eng_wr_r.we && eng_wr_r.addr == rx_ptr_r[7:0])) else $error("fixed length missed");
	a_short_err: assert property ((gap_to && !rx_acc && !flush) |=> rx_fin_r && rx_err_r)
		else $error("short message not flagged");

	c_tx_msg: cover property (tx_done ##1 tx_cmd_r == rmb_pkg::TXC_IDLE);
	c_rx_msg: cover property (rx_cmd_r == rmb_pkg::RXC_READY ##[1:300] rx_cmd_r == rmb_pkg::RXC_DONE);
	c_rx_err: cover property (rx_cmd_r == rmb_pkg::RXC_ERR);
	c_pt_cycle: cover property (pt_act_r ##[1:1000] !pt_act_r);
endmodule : rmb_bridge
`default_nettype wire

// *** rmb_port_model.sv ***
`default_nettype none
// =====================================================================
// far-side serial device: takes sent bytes, offers received bytes
module rmb_port_model (
	// clock
	input  wire logic       aclk,
	// byte streams
	input  wire logic       tx_byte_valid,
	input  wire logic [7:0] tx_byte_data,
	output var logic        tx_byte_ready,
	output var logic        rx_byte_valid,
	output var logic [7:0]  rx_byte_data
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] got[$];
	// ready has a single driver, the stall process below
	initial begin
		rx_byte_valid = 1'b0;
		rx_byte_data = 8'h5A;
	end
	// random stalls stretch the hold time of each sent byte
	always @(posedge aclk) begin
		if (tx_byte_valid && tx_byte_ready) got.push_back(tx_byte_data);
		tx_byte_ready <= ($urandom_range(2) == 0);
	end
	// one-cycle pulse; afterwards the line shows the inverse, never a stale byte
	task automatic send(input logic [7:0] v);
		rx_byte_valid <= 1'b1;
		rx_byte_data <= v;
		@(posedge aclk);
		rx_byte_valid <= 1'b0;
		rx_byte_data <= ~v;
		repeat (2) @(posedge aclk);
	endtask
endmodule // rmb_port_model
`default_nettype wire

// *** testbench.sv ***
`default_nettype none
// =====================================================================
// self-checking bench for the mailbox bridge
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [11:0] TXC = 12'h004;
	localparam logic [11:0] RXC = 12'h00C;
	logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready, rx_byte_valid, tx_byte_valid, tx_byte_ready;
	logic        raw_mode_sel, pc_traffic, bridge_active, bridge_eth, bridge_udp, bridge_ctrl2;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rsp, bridge_port;
	logic [7:0]  rx_byte_data, tx_byte_data;
	logic [15:0] bridge_tcp_port;
	logic [7:0]  b[5];
	int          errors, checks, cyc;
	rmb_bridge #(.SEC_CYC(20), .GAP_CYC(16)) i_rmb_bridge (.aclk, .aresetn, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .rx_byte_valid, .rx_byte_data, .tx_byte_valid, .tx_byte_data,
		.tx_byte_ready, .raw_mode_sel, .pc_traffic, .bridge_active, .bridge_eth,
		.bridge_port, .bridge_udp, .bridge_ctrl2, .bridge_tcp_port);
	rmb_port_model i_rmb_port_model (.aclk, .tx_byte_valid, .tx_byte_data, .tx_byte_ready,
		.rx_byte_valid, .rx_byte_data);
	initial aclk = 1'b0;
	always #25 aclk = ~aclk;
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			errors++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic print_verdict();
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// expected buffer word: high byte first, upper half reads zero
	function automatic logic [31:0] pack_word(input logic [7:0] hi, input logic [7:0] lo);
		return {16'h0, hi, lo};
	endfunction
	// bready rises once both halves are taken and drops after the response
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF);
		logic aw, w;
		aw = 1'b0;
		w = 1'b0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		forever begin
			@(posedge aclk);
			if (s_axi_bvalid && s_axi_bready) break;
			if (s_axi_awready) aw = 1'b1;
			if (s_axi_wready) w = 1'b1;
			if (aw) s_axi_awvalid <= 1'b0;
			if (w) s_axi_wvalid <= 1'b0;
			if (aw && w) s_axi_bready <= 1'b1;
		end
		s_axi_bready <= 1'b0;
		rsp = s_axi_bresp;
	endtask
	task automatic rdr(input logic [11:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		@(posedge aclk);
		while (!s_axi_arready) @(posedge aclk);
		s_axi_arvalid <= 1'b0;
		s_axi_rready <= 1'b1;
		@(posedge aclk);
		while (!s_axi_rvalid) @(posedge aclk);
		s_axi_rready <= 1'b0;
		rd = s_axi_rdata;
		rsp = s_axi_rresp;
	endtask
	// polls a register until it shows the value or the tries run out
	task automatic poll(input logic [11:0] a, input logic [31:0] e);
		for (int i = 0; i < 60; i++) begin
			rdr(a);
			if (rd === e) break;
		end
	endtask
	// cuts a hang short
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			errors++;
			print_verdict();
		end
	end
	initial begin
		void'($urandom(32'hA897));
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, pc_traffic} = 5'h00;
		{s_axi_bready, s_axi_rready} = 2'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 56'h0;
		{s_axi_wstrb, raw_mode_sel} = 5'h1F;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		rdr(RXC);
		chk(rd, 32'h3);
		rdr(rmb_pkg::ADDR_NET);
		chk(rd, 32'h1774);
		rdr(12'h030);
		chk(rsp, rmb_pkg::RESP_SLVERR);
		wr(rmb_pkg::ADDR_STAT, 32'h1);
		chk(rsp, rmb_pkg::RESP_SLVERR);
		$display("test reset done");
		for (int i = 0; i < 5; i++) b[i] = 8'($urandom);
		wr(12'h000, 32'h4);
		wr(12'h410, 32'h3);
		wr(12'h414, {16'h0, b[0], b[1]});
		wr(12'h418, {16'h0, b[2], 8'hEE});
		wr(TXC, 32'h1);
		poll(TXC, 32'h0);
		chk(rd, 32'h0);
		chk(32'(i_rmb_port_model.got.size()), 32'h3);
		for (int i = 0; i < 3; i++) chk(i_rmb_port_model.got[i], b[i]);
		$display("test transmit done");
		wr(12'h008, 32'h20);
		wr(12'h014, 32'h5);
		i_rmb_port_model.send(8'h77);
		rdr(rmb_pkg::ADDR_STAT);
		chk(rd[7:0], 32'h0);
		wr(RXC, 32'h0);
		for (int i = 0; i < 5; i++) i_rmb_port_model.send(b[i]);
		poll(RXC, 32'h1);
		chk(rd, 32'h1);
		rdr(12'h480);
		chk(rd, 32'h5);
		rdr(12'h484);
		chk(rd, pack_word(b[0], b[1]));
		rdr(12'h48C);
		chk(rd, pack_word(b[4], 8'h00));
		$display("test fixed length done");
		wr(12'h014, 32'h0);
		wr(12'h010, 32'h0A0D);
		wr(RXC, 32'h0);
		i_rmb_port_model.send(8'h41);
		i_rmb_port_model.send(8'h42);
		i_rmb_port_model.send(8'h0A);
		i_rmb_port_model.send(8'h0D);
		poll(RXC, 32'h1);
		chk(rd, 32'h1);
		rdr(12'h484);
		chk(rd, 32'h4142);
		$display("test terminator done");
		wr(12'h014, 32'hAB04, 4'h1);
		rdr(12'h014);
		chk(rd, 32'h4);
		wr(RXC, 32'h0);
		i_rmb_port_model.send(b[0]);
		poll(RXC, 32'hFFFF);
		chk(rd, 32'hFFFF);
		rdr(12'h480);
		chk(rd, 32'h1);
		wr(RXC, 32'h2);
		rdr(RXC);
		chk(rd, 32'h3);
		$display("test short and flush done");
		wr(RXC, 32'h0);
		wr(rmb_pkg::ADDR_CFG, 32'hB);
		wr(rmb_pkg::ADDR_TOUT, 32'h1);
		wr(rmb_pkg::ADDR_NET, 32'h31234);
		chk({bridge_eth, bridge_port, bridge_udp, bridge_ctrl2}, 32'h17);
		chk(bridge_tcp_port, 32'h1234);
		raw_mode_sel <= 1'b0;
		@(posedge aclk);
		rdr(RXC);
		chk(rd, 32'h3);
		pc_traffic <= 1'b1;
		@(posedge aclk);
		pc_traffic <= 1'b0;
		@(posedge aclk);
		chk(bridge_active, 32'h1);
		repeat (10) @(posedge aclk);
		chk(bridge_active, 32'h1);
		repeat (30) @(posedge aclk);
		chk(bridge_active, 32'h0);
		$display("test bridging done");
		print_verdict();
	end
endmodule // testbench
`default_nettype wire
